// ---- core/codec_status_params.svh ----
// Offsets, field positions and reset values of the codec status bank
`ifndef CODEC_STATUS_PARAMS_SVH
`define CODEC_STATUS_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_INTERPOLATOR_STATUS    7'h18
`define IDX_DECIMATOR_STATUS       7'h28
`define IDX_DIGITAL_INPUT_STATUS   7'h59
`define IDX_RX_CHSTAT_LEFT_LOW     7'h5a
`define IDX_RX_CHSTAT_LEFT_MID     7'h5b
`define IDX_RX_CHSTAT_LEFT_HIGH    7'h5c
`define IDX_RX_CHSTAT_RIGHT_LOW    7'h5d
`define IDX_RX_CHSTAT_RIGHT_MID    7'h5e
`define IDX_RX_CHSTAT_RIGHT_HIGH   7'h5f
`define IDX_IRQ_STATUS             7'h60
`define IDX_IRQ_MASK               7'h61

// ****************************************************************
// Field positions
// ****************************************************************
`define POS_SILENCE_CH2_RIGHT      6
`define POS_SILENCE_CH2_LEFT       5
`define POS_SILENCE_CH1_RIGHT      4
`define POS_SILENCE_CH1_LEFT       3
`define POS_INTERP_MUTED           2
`define POS_INTERP_CH2_MUTED       1
`define POS_INTERP_CH1_MUTED       0
`define POS_DECIMATOR_MUTED        2
`define POS_DECIMATOR_OVERFLOW     0
`define POS_ENCODER_OUT_DISABLED   8
`define POS_BIPHASE_ERROR          1
`define POS_RX_LOCKED              0

// Interrupt status bits
`define IRQ_BLOCK_CAPTURED         0
`define IRQ_BIPHASE_ERROR          1
`define IRQ_OVERFLOW               2
`define IRQ_LOCK_CHANGE            3
`define IRQ_WORDLEN_RESERVED       4
`define IRQ_WIDTH                  5

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define RST_CHSTAT                 40'h00_0000_0000
`define RST_IRQ                    5'h00
`define CHSTAT_BITS                40
`define CHSTAT_CNT_LAST            6'h27
`define READ_ZERO                  32'h0000_0000

`endif

// ---- core/codec_status_pkg.sv ----
// Types shared by the codec status bank
package codec_status_pkg;

  // Live status levels from the codec core
  typedef struct packed {
    logic [3:0] silence;          // ch2 right, ch2 left, ch1 right, ch1 left
    logic       interpMuted;
    logic       interpCh2Muted;
    logic       interpCh1Muted;
    logic       decimatorMuted;
    logic       decimatorOverflow;
    logic       encoderOutputDisabled;
    logic       biphaseError;
    logic       rxLocked;
  } core_status_t;

  // One channel-status bit pair from the decoder
  typedef struct packed {
    logic valid;
    logic blockStart;
    logic bitLeft;
    logic bitRight;
  } chstat_bit_t;

  typedef enum logic [1:0] {CAP_IDLE, CAP_SHIFT, CAP_WAIT} cap_state_t;

endpackage

// ---- core/codec_status_readback.sv ----
// Status register bank of the stereo codec, read-only except the IRQ mask and IRQ status clear, with Avalon-MM slave
`timescale 1ns/1ns
`include "codec_status_params.svh"

module codec_status_readback (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // Avalon-MM slave
  input  wire logic [8:0]                    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [3:0]                    byteenable,
  input  wire logic [31:0]                   writedata,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  // Codec core status and decoder stream
  input  wire codec_status_pkg::core_status_t coreStatus,
  input  wire codec_status_pkg::chstat_bit_t  chstatIn,
  // Interrupt
  output logic                               irq
);

  // ****************************************************************
  // Channel-status word-length decode
  // ****************************************************************
  function automatic logic wordLenReserved(input logic [3:0] code);
    // Pattern on bits 35..33 of 011 or 111 is reserved in both ranges
    wordLenReserved = (code[3:1] == 3'b011) || (code[3:1] == 3'b111);
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] readData_ff;
  logic [31:0] nxt_read;
  wire  logic  busReq    = read | write;
  wire  logic  writeTake = write & ack_ff;
  wire  logic [6:0] regIdx = address[8:2];

  // One wait cycle: data is registered in the first cycle, taken in the second
  assign nxt_ack     = busReq & ~ack_ff;
  assign waitrequest = busReq & ~ack_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // ****************************************************************
  // Channel-status capture
  // ****************************************************************
  codec_status_pkg::cap_state_t capState_ff;
  codec_status_pkg::cap_state_t nxt_capState;
  logic [39:0] shiftLeft_ff;
  logic [39:0] shiftRight_ff;
  logic [39:0] chstatLeft_ff;
  logic [39:0] chstatRight_ff;
  logic [5:0]  bitCnt_ff;
  logic        lockPrev_ff;
  logic        errPrev_ff;
  logic        ovfPrev_ff;

  // Bit 0 arrives first and ends up in bit 0 of the captured word
  wire logic [39:0] nxt_shiftLeft  = {chstatIn.bitLeft, shiftLeft_ff[39:1]};
  wire logic [39:0] nxt_shiftRight = {chstatIn.bitRight, shiftRight_ff[39:1]};
  wire logic        startBit  = chstatIn.valid & chstatIn.blockStart & coreStatus.rxLocked;
  wire logic        lastBit   = (capState_ff == codec_status_pkg::CAP_SHIFT) &
                                chstatIn.valid & ~chstatIn.blockStart &
                                (bitCnt_ff == `CHSTAT_CNT_LAST);
  wire logic        blockDone = lastBit & coreStatus.rxLocked;
  wire logic [5:0]  nxt_bitCnt = startBit ? 6'h01 :
                                 (chstatIn.valid ? bitCnt_ff + 6'h01 : bitCnt_ff);

  always_comb begin
    nxt_capState = capState_ff;
    unique case (capState_ff)
      codec_status_pkg::CAP_IDLE: begin
        if (startBit) begin
          nxt_capState = codec_status_pkg::CAP_SHIFT;
        end
      end
      codec_status_pkg::CAP_SHIFT: begin
        // Loss of lock abandons the partial block
        if (!coreStatus.rxLocked) begin
          nxt_capState = codec_status_pkg::CAP_IDLE;
        end else if (blockDone) begin
          nxt_capState = codec_status_pkg::CAP_WAIT;
        end else if (startBit) begin
          nxt_capState = codec_status_pkg::CAP_SHIFT;
        end
      end
      codec_status_pkg::CAP_WAIT: begin
        if (!coreStatus.rxLocked) begin
          nxt_capState = codec_status_pkg::CAP_IDLE;
        end else if (startBit) begin
          nxt_capState = codec_status_pkg::CAP_SHIFT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capState_ff <= codec_status_pkg::CAP_IDLE;
      bitCnt_ff   <= 6'h00;
    end else begin
      capState_ff <= nxt_capState;
      bitCnt_ff   <= nxt_bitCnt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shiftLeft_ff  <= `RST_CHSTAT;
      shiftRight_ff <= `RST_CHSTAT;
    end else if (chstatIn.valid) begin
      shiftLeft_ff  <= nxt_shiftLeft;
      shiftRight_ff <= nxt_shiftRight;
    end
  end

  // Both sides are committed in one edge so a read never mixes blocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chstatLeft_ff  <= `RST_CHSTAT;
      chstatRight_ff <= `RST_CHSTAT;
    end else if (blockDone) begin
      chstatLeft_ff  <= nxt_shiftLeft;
      chstatRight_ff <= nxt_shiftRight;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [`IRQ_WIDTH-1:0] irqStatus_ff;
  logic [`IRQ_WIDTH-1:0] irqMask_ff;
  logic [`IRQ_WIDTH-1:0] irqEvent;
  logic [`IRQ_WIDTH-1:0] irqClear;

  assign irqEvent[`IRQ_BLOCK_CAPTURED]   = blockDone;
  assign irqEvent[`IRQ_BIPHASE_ERROR]    = coreStatus.biphaseError & ~errPrev_ff;
  assign irqEvent[`IRQ_OVERFLOW]         = coreStatus.decimatorOverflow & ~ovfPrev_ff;
  assign irqEvent[`IRQ_LOCK_CHANGE]      = coreStatus.rxLocked ^ lockPrev_ff;
  assign irqEvent[`IRQ_WORDLEN_RESERVED] = blockDone &
                                           (wordLenReserved(nxt_shiftLeft[35:32]) |
                                            wordLenReserved(nxt_shiftRight[35:32]));

  wire logic selIrqStatus = writeTake & (regIdx == `IDX_IRQ_STATUS) & byteenable[0];
  wire logic selIrqMask   = writeTake & (regIdx == `IDX_IRQ_MASK) & byteenable[0];
  assign irqClear = selIrqStatus ? writedata[`IRQ_WIDTH-1:0] : `RST_IRQ;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lockPrev_ff <= 1'b0;
      errPrev_ff  <= 1'b0;
      ovfPrev_ff  <= 1'b0;
    end else begin
      lockPrev_ff <= coreStatus.rxLocked;
      errPrev_ff  <= coreStatus.biphaseError;
      ovfPrev_ff  <= coreStatus.decimatorOverflow;
    end
  end

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_ff <= `RST_IRQ;
      irqMask_ff   <= `RST_IRQ;
    end else begin
      irqStatus_ff <= (irqStatus_ff & ~irqClear) | irqEvent;
      if (selIrqMask) begin
        irqMask_ff <= writedata[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irqStatus_ff & irqMask_ff);

  // ****************************************************************
  // Read-only status words
  // ****************************************************************
  wire logic [15:0] interpWord = {9'h000,
                                  coreStatus.silence,
                                  coreStatus.interpMuted,
                                  coreStatus.interpCh2Muted,
                                  coreStatus.interpCh1Muted};
  wire logic [15:0] decimWord  = {13'h0000,
                                  coreStatus.decimatorMuted,
                                  1'b0,
                                  coreStatus.decimatorOverflow};
  wire logic [15:0] dinWord    = {7'h00,
                                  coreStatus.encoderOutputDisabled,
                                  6'h00,
                                  coreStatus.biphaseError,
                                  coreStatus.rxLocked};

  // Reads have no side effect; writes do nothing except at the IRQ status (clear) and IRQ mask indices
  always_comb begin
    nxt_read = `READ_ZERO;
    unique case (regIdx)
      `IDX_INTERPOLATOR_STATUS:  nxt_read = {16'h0000, interpWord};
      `IDX_DECIMATOR_STATUS:     nxt_read = {16'h0000, decimWord};
      `IDX_DIGITAL_INPUT_STATUS: nxt_read = {16'h0000, dinWord};
      `IDX_RX_CHSTAT_LEFT_LOW:   nxt_read = {16'h0000, chstatLeft_ff[15:0]};
      `IDX_RX_CHSTAT_LEFT_MID:   nxt_read = {16'h0000, chstatLeft_ff[31:16]};
      `IDX_RX_CHSTAT_LEFT_HIGH:  nxt_read = {24'h00_0000, chstatLeft_ff[39:32]};
      `IDX_RX_CHSTAT_RIGHT_LOW:  nxt_read = {16'h0000, chstatRight_ff[15:0]};
      `IDX_RX_CHSTAT_RIGHT_MID:  nxt_read = {16'h0000, chstatRight_ff[31:16]};
      `IDX_RX_CHSTAT_RIGHT_HIGH: nxt_read = {24'h00_0000, chstatRight_ff[39:32]};
      `IDX_IRQ_STATUS:           nxt_read = {27'h000_0000, irqStatus_ff};
      `IDX_IRQ_MASK:             nxt_read = {27'h000_0000, irqMask_ff};
      default:                   nxt_read = `READ_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readData_ff <= `READ_ZERO;
    end else if (read & ~ack_ff) begin
      readData_ff <= nxt_read;
    end
  end

  assign readdata = readData_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_readOpen;
    read & ~ack_ff;
  endsequence

  sequence s_readDone;
    read & ack_ff & ~waitrequest;
  endsequence

  a_interp_silence_read: assert property (
    (s_readOpen and (regIdx == `IDX_INTERPOLATOR_STATUS)) ##1 s_readDone
      |-> readdata[6:3] == $past(coreStatus.silence))
    else $error("interpolator silence bits wrong");

  a_interp_mute_read: assert property (
    (s_readOpen and (regIdx == `IDX_INTERPOLATOR_STATUS)) ##1 s_readDone
      |-> readdata[2] == $past(coreStatus.interpMuted))
    else $error("interpolator mute bit wrong");

  a_interp_chmute_read: assert property (
    (s_readOpen and (regIdx == `IDX_INTERPOLATOR_STATUS)) ##1 s_readDone
      |-> readdata[1:0] == {$past(coreStatus.interpCh2Muted), $past(coreStatus.interpCh1Muted)})
    else $error("interpolator channel mute bits wrong");

  a_interp_reserved_zero: assert property (
    (s_readOpen and (regIdx == `IDX_INTERPOLATOR_STATUS)) ##1 s_readDone
      |-> readdata[15:7] == 9'h000)
    else $error("interpolator reserved bits not zero");

  a_decim_status_read: assert property (
    (s_readOpen and (regIdx == `IDX_DECIMATOR_STATUS)) ##1 s_readDone
      |-> readdata[15:0] == {13'h0000, $past(coreStatus.decimatorMuted), 1'b0,
                             $past(coreStatus.decimatorOverflow)})
    else $error("decimator status word wrong");

  a_ovf_irq_set: assert property (
    $rose(coreStatus.decimatorOverflow) |=> irqStatus_ff[`IRQ_OVERFLOW])
    else $error("overflow event not latched");

  a_din_status_read: assert property (
    (s_readOpen and (regIdx == `IDX_DIGITAL_INPUT_STATUS)) ##1 s_readDone
      |-> readdata[15:0] == {7'h00, $past(coreStatus.encoderOutputDisabled), 6'h00,
                             $past(coreStatus.biphaseError), $past(coreStatus.rxLocked)})
    else $error("digital input status word wrong");

  a_err_irq_set: assert property (
    $rose(coreStatus.biphaseError) |=> irqStatus_ff[`IRQ_BIPHASE_ERROR])
    else $error("biphase error event not latched");

  a_unlock_abort: assert property (
    $fell(coreStatus.rxLocked) |=> capState_ff == codec_status_pkg::CAP_IDLE)
    else $error("capture continued out of lock");

  a_chstat_high_map: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_LEFT_HIGH)) ##1 s_readDone
      |-> readdata[15:0] == {8'h00, $past(chstatLeft_ff[39:32])})
    else $error("left high channel status word wrong");

  a_chstat_mid_map: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_RIGHT_MID)) ##1 s_readDone
      |-> readdata[15:0] == $past(chstatRight_ff[31:16]))
    else $error("right mid channel status word wrong");

  a_chstat_low_map: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_LEFT_LOW)) ##1 s_readDone
      |-> readdata[15:0] == $past(chstatLeft_ff[15:0]))
    else $error("left low channel status word wrong");

  a_chstat_hold: assert property (
    !blockDone |=> $stable(chstatLeft_ff) && $stable(chstatRight_ff))
    else $error("channel status changed outside block commit");

  a_write_ignored: assert property (
    (writeTake && regIdx <= `IDX_RX_CHSTAT_RIGHT_HIGH && !blockDone)
      |=> $stable(chstatLeft_ff) && $stable(chstatRight_ff))
    else $error("write altered read-only status");

  a_wait_one_cycle: assert property (
    (busReq && !ack_ff) |-> waitrequest ##1 !waitrequest)
    else $error("wait state not exactly one cycle");

  a_chstat_right_high: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_RIGHT_HIGH)) ##1 s_readDone
      |-> readdata[15:0] == {8'h00, $past(chstatRight_ff[39:32])})
    else $error("right high channel status word wrong");

  a_chstat_left_mid: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_LEFT_MID)) ##1 s_readDone
      |-> readdata[15:0] == $past(chstatLeft_ff[31:16]))
    else $error("left mid channel status word wrong");

  a_chstat_right_low: assert property (
    (s_readOpen and (regIdx == `IDX_RX_CHSTAT_RIGHT_LOW)) ##1 s_readDone
      |-> readdata[15:0] == $past(chstatRight_ff[15:0]))
    else $error("right low channel status word wrong");

  a_din_reserved_zero: assert property (
    (s_readOpen and (regIdx == `IDX_DIGITAL_INPUT_STATUS)) ##1 s_readDone
      |-> readdata[31:9] == 23'h00_0000 && readdata[7:2] == 6'h00)
    else $error("digital input reserved bits not zero");

  a_block_irq_set: assert property (
    blockDone |=> irqStatus_ff[`IRQ_BLOCK_CAPTURED])
    else $error("captured block event not latched");

  a_wordlen_irq_set: assert property (
    (blockDone && (wordLenReserved(nxt_shiftLeft[35:32]) ||
                   wordLenReserved(nxt_shiftRight[35:32])))
      |=> irqStatus_ff[`IRQ_WORDLEN_RESERVED])
    else $error("reserved word length event not latched");

  a_read_no_clear: assert property (
    (read && !write) |=> (irqStatus_ff & $past(irqStatus_ff)) == $past(irqStatus_ff))
    else $error("read cleared a status bit");

  a_read_data_hold: assert property (
    !(read && !ack_ff) |=> $stable(readdata))
    else $error("read data changed without a read");

endmodule // codec_status_readback

// ---- bench/test_codec_status_readback.sv ----
// Self-checking testbench of the codec status register bank
`timescale 1ns/1ns
`include "codec_status_params.svh"

module test_codec_status_readback;
  logic                           clk;
  logic                           resetn;
  logic [8:0]                     address;
  logic                           read;
  logic                           write;
  logic [3:0]                     byteenable;
  logic [31:0]                    writedata;
  logic [31:0]                    readdata;
  logic                           waitrequest;
  codec_status_pkg::core_status_t coreStatus;
  codec_status_pkg::chstat_bit_t  chstatIn;
  logic                           irq;
  int                             n_fail;
  int                             comparisons;
  logic [31:0]                    q;
  logic [39:0]                    capL;
  logic [39:0]                    capR;
  logic [39:0]                    newL;
  logic [39:0]                    newR;
  logic [11:0]                    rnd;

  codec_status_readback dut (
    .clk        (clk),
    .resetn     (resetn),
    .address    (address),
    .read       (read),
    .write      (write),
    .byteenable (byteenable),
    .writedata  (writedata),
    .readdata   (readdata),
    .waitrequest(waitrequest),
    .coreStatus (coreStatus),
    .chstatIn   (chstatIn),
    .irq        (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // Expectations and compares
  // ****************************************************************
  function automatic logic [31:0] expInterp(input codec_status_pkg::core_status_t s);
    return {25'h000_0000, s.silence, s.interpMuted, s.interpCh2Muted, s.interpCh1Muted};
  endfunction

  function automatic logic [31:0] expDecim(input codec_status_pkg::core_status_t s);
    return {29'h0000_0000, s.decimatorMuted, 1'b0, s.decimatorOverflow};
  endfunction

  function automatic logic [31:0] expDin(input codec_status_pkg::core_status_t s);
    return {23'h00_0000, s.encoderOutputDisabled, 6'h00, s.biphaseError, s.rxLocked};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkIrq(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t irq got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Bus and stream drivers
  // ****************************************************************
  // Entered just after a rising edge; holds the request until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [6:0] idx, input logic [31:0] d);
    address    <= {idx, 2'b00};
    writedata  <= d;
    write      <= wr;
    read       <= !wr;
    byteenable <= 4'hf;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdChk(input logic [6:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    check(q, exp);
  endtask

  task automatic irqIs(input logic exp);
    @(negedge clk);
    checkIrq(irq, exp);
    @(posedge clk);
  endtask

  // Lock is dropped together with bit abortAt; pass 99 for a clean block
  task automatic sendBlock(input logic [39:0] l, input logic [39:0] r, input int abortAt);
    for (int i = 0; i < 40; i++) begin
      chstatIn <= '{1'b1, (i == 0), l[i], r[i]};
      if (i == abortAt) coreStatus.rxLocked <= 1'b0;
      @(posedge clk);
      chstatIn.valid <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic chkBlock(input logic [39:0] l, input logic [39:0] r);
    rdChk(`IDX_RX_CHSTAT_LEFT_LOW, {16'h0000, l[15:0]});
    rdChk(`IDX_RX_CHSTAT_LEFT_MID, {16'h0000, l[31:16]});
    rdChk(`IDX_RX_CHSTAT_LEFT_HIGH, {24'h00_0000, l[39:32]});
    rdChk(`IDX_RX_CHSTAT_RIGHT_LOW, {16'h0000, r[15:0]});
    rdChk(`IDX_RX_CHSTAT_RIGHT_MID, {16'h0000, r[31:16]});
    rdChk(`IDX_RX_CHSTAT_RIGHT_HIGH, {24'h00_0000, r[39:32]});
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0; read = 1'b0; write = 1'b0; address = 9'h000; byteenable = 4'hf;
    writedata = 32'h0000_0000; coreStatus = '0; chstatIn = '0;
    n_fail = 0; comparisons = 0; capL = '0; capR = '0;
    rnd = 12'($urandom(52154));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chkBlock(capL, capR);
    rdChk(`IDX_IRQ_STATUS, 32'h0000_0000);
    // Live status words, all-zero and all-one first, then random
    for (int k = 0; k < 40; k++) begin
      rnd = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
      coreStatus <= rnd;
      @(posedge clk);
      rdChk(`IDX_INTERPOLATOR_STATUS, expInterp(rnd));
      rdChk(`IDX_DECIMATOR_STATUS, expDecim(rnd));
      rdChk(`IDX_DIGITAL_INPUT_STATUS, expDin(rnd));
      xfer(1'b1, `IDX_DIGITAL_INPUT_STATUS, 32'hffff_ffff);
      rdChk(`IDX_DIGITAL_INPUT_STATUS, expDin(rnd));
    end
    xfer(1'b1, `IDX_RX_CHSTAT_LEFT_LOW, 32'hffff_ffff);
    rdChk(`IDX_RX_CHSTAT_LEFT_LOW, 32'h0000_0000);
    rdChk(7'h7f, 32'h0000_0000);
    // Quiet, locked core; pending events cleared
    coreStatus <= 12'h001;
    repeat (3) @(posedge clk);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h0000_0000);
    xfer(1'b1, `IDX_IRQ_STATUS, 32'h0000_001f);
    rdChk(`IDX_IRQ_STATUS, 32'h0000_0000);
    // Every pattern of word-length bits 35..33, one captured block each
    for (int wl = 0; wl < 8; wl++) begin
      newL = {8'($urandom), 32'($urandom)};
      newR = {8'($urandom), 32'($urandom)};
      newL[35:33] = 3'(wl);
      newR[35:33] = 3'(wl);
      sendBlock(newL, newR, 99);
      capL = newL;
      capR = newR;
      chkBlock(capL, capR);
      rdChk(`IDX_IRQ_STATUS, {27'h000_0000, (wl == 3 || wl == 7), 4'h1});
      if (wl == 0) begin
        irqIs(1'b0);
        xfer(1'b1, `IDX_IRQ_MASK, 32'h0000_0001);
        irqIs(1'b1);
      end
      xfer(1'b1, `IDX_IRQ_STATUS, 32'h0000_001f);
      irqIs(1'b0);
    end
    // Lock lost mid-block: old words must survive untouched
    sendBlock(~capL, ~capR, 20);
    chkBlock(capL, capR);
    rdChk(`IDX_IRQ_STATUS, 32'h0000_0008);
    coreStatus.rxLocked <= 1'b1;
    @(posedge clk);
    xfer(1'b1, `IDX_IRQ_STATUS, 32'h0000_001f);
    // Overflow and biphase error rising edges
    coreStatus.decimatorOverflow <= 1'b1;
    coreStatus.biphaseError      <= 1'b1;
    @(posedge clk);
    rdChk(`IDX_IRQ_STATUS, 32'h0000_0006);
    xfer(1'b1, `IDX_IRQ_MASK, 32'h0000_0004);
    irqIs(1'b1);
    rdChk(`IDX_DIGITAL_INPUT_STATUS, 32'h0000_0003);
    end_of_test;
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    end_of_test;
  end
endmodule // test_codec_status_readback
